//--- rtl/bpct_pad.sv
`timescale 1ns/100ps

//--- rtl/bpct_pkg.sv
// Constants and types for the brushless PWM and commutation timer
// Functional notes
// - Auto-scaling 8-bit timer measures zero-crossing intervals
// - Zero-cross captures timer, then restarts it
// - Old capture moves to previous-interval register
// - Commutation delay is interval times weight
// - 12-bit carrier runs beside interval timer
// - PWM compares carrier with two-byte duty value
// - PWM steered to one of three upper switches (0, 2, 4)
// - User-chosen complementary switch also turned on
// - Back-EMF and Hall events handled alike
// - Carrier counts up to maximum, down to zero
// - Duty-update event after programmed carrier repetitions
// - Duty-update event at centre of on-time for odd repetition counts
// - Carrier rate is clock over prescale*2*max
// - Update period is carrier*(repetition+1)/2
// - Pending flag cleared by writing zero bit
package bpct_pkg;
  localparam int          CARRIER_W   = 12;       // Carrier width
  localparam int          TIMER_W     = 8;        // Interval timer width
  localparam int          SCALE_W     = 4;        // Auto-scale exponent width
  localparam int          TB_W        = 24;       // Timebase counter width
  localparam int          SW_N        = 6;        // Inverter switches
  localparam logic [3:0]  SCALE_MAX   = 4'hf;     // Largest scale exponent
  localparam logic [3:0]  SCALE_RST   = 4'h0;     // Scale after reset
  localparam logic [7:0]  TIMER_FULL  = 8'hff;    // Timer overflow point
  localparam logic [7:0]  TIMER_HALF  = 8'h80;    // Timer after scale-up
  localparam logic [7:0]  TIMER_LOW   = 8'h40;    // Below this, scale down
  localparam logic [7:0]  BYTE_RST    = 8'h00;    // Byte reset value
  localparam logic [11:0] CARRIER_RST = 12'h000;  // Carrier reset value
  localparam logic [2:0]  STEP_LAST   = 3'h5;     // Last commutation step
  localparam int          PEND_BIT    = 0;        // Pending flag position
  localparam int          WEIGHT_SH   = 8;        // Weight is fraction /256

  // Carrier direction
  typedef enum logic [0:0] {
    BPCT_UP   = 1'b0,
    BPCT_DOWN = 1'b1
  } bpct_dir_t;

  // Duty compare value as written by software
  typedef struct packed {
    logic [7:0] hi;   // High byte, low nibble used
    logic [7:0] lo;   // Low byte
  } bpct_duty_t;

  // Interval measurement results
  typedef struct packed {
    logic [7:0] cur;   // Current interval capture
    logic [7:0] prev;  // Previous interval capture
    logic [3:0] scale; // Timebase exponent of the running timer
  } bpct_interval_t;
endpackage

//--- rtl/bpct_timer.sv
// Top of the brushless PWM carrier, steering and commutation timer
`timescale 1ns/100ps
module bpct_timer #(
  parameter int PRESC  = 1,   // Carrier prescaler
  parameter int TB_DIV = 16   // Interval timebase divider at scale 0
) (
  input  wire logic                i_clk,          // 50 MHz clock
  input  wire logic                i_srst,         // Sync reset, high
  input  wire logic                i_zc_bemf,      // Back-EMF zero-cross pulse
  input  wire logic                i_zc_hall,      // Hall edge pulse
  input  wire logic                i_zc_use_hall,  // 1: Hall is source
  input  wire logic [7:0]          i_commutation_delay_weight, // /256
  input  wire logic [11:0]         i_carrier_period_max, // Carrier top
  input  wire logic [7:0]          i_update_repetition_count, // Half-cycles-1
  input  wire logic                i_duty_wr,      // Duty write strobe
  input  wire bpct_pkg::bpct_duty_t i_duty,        // Duty bytes
  input  wire logic [2:0]          i_comp_switch,  // Complementary switch
  input  wire logic                i_irq_status_wr, // Status write strobe
  input  wire logic [7:0]          i_irq_status_data, // Status write data
  output logic [5:0]               o_switch,       // Inverter gate drives
  output logic                     o_pwm,          // Raw PWM
  output logic [11:0]              o_carrier,      // Carrier count
  output logic                     o_duty_update_event, // Update pulse
  output logic                     o_duty_update_pending_flag, // Irq flag
  output logic                     o_commutate,    // Commutation pulse
  output logic [2:0]               o_step,         // Commutation step
  output bpct_pkg::bpct_interval_t o_interval      // Interval captures
);

  // Carrier group state
  logic [15:0]        presc_q, presc_d;         // Prescaler count
  logic [11:0]        carrier_q, carrier_d;     // Carrier count
  bpct_pkg::bpct_dir_t dir_q, dir_d;            // Count direction
  logic [7:0]         rep_q, rep_d;             // Half-cycles seen
  bpct_pkg::bpct_duty_t pre_q, pre_d;           // Preloaded duty
  logic [11:0]        duty_q, duty_d;           // Active compare
  logic               pwm_q, pwm_d;             // Registered PWM
  logic               upd_q, upd_d;             // Update pulse
  logic               pend_q, pend_d;           // Pending flag
  logic [5:0]         sw_q, sw_d;               // Switch drives

  // Interval group state
  logic [23:0]        tb_q, tb_d;               // Timebase count
  logic [7:0]         tmr_q, tmr_d;             // Interval timer
  logic [3:0]         scale_q, scale_d;         // Timebase exponent
  logic [7:0]         cur_q, cur_d;             // Current capture
  logic [7:0]         prev_q, prev_d;           // Previous capture
  logic [8:0]         tgt_q, tgt_d;             // Delay target
  logic [8:0]         dly_q, dly_d;             // Delay count
  logic               armed_q, armed_d;         // Delay running
  logic               com_q, com_d;             // Commutation pulse
  logic [2:0]         step_q, step_d;           // Commutation step

  // One-hot switch select, used for the PWM and the complementary leg
  function automatic logic [5:0] onehot(input logic [2:0] idx);
    logic [5:0] v;
    v = 6'h00;
    if (idx < 3'(bpct_pkg::SW_N)) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction

  // Upper switch that carries PWM in each step
  function automatic logic [2:0] pwm_leg(input logic [2:0] step);
    logic [2:0] v;
    v = {step[2:1], 1'b0};
    return v;
  endfunction

  // Carrier, repetition, duty preload, flag and steering
  always_comb begin
    logic tick;
    logic half_end;
    tick      = (presc_q >= 16'(PRESC - 1));
    half_end  = 1'b0;
    presc_d   = tick ? 16'h0000 : presc_q + 16'h0001;
    carrier_d = carrier_q;
    dir_d     = dir_q;
    rep_d     = rep_q;
    pre_d     = pre_q;
    duty_d    = duty_q;
    upd_d     = 1'b0;
    if (tick) begin
      // Up to the maximum, back down to zero, forever
      if (dir_q == bpct_pkg::BPCT_UP) begin
        if (carrier_q >= i_carrier_period_max) begin
          dir_d     = bpct_pkg::BPCT_DOWN;
          half_end  = 1'b1;
          carrier_d = (carrier_q == 12'h000) ? 12'h000 : carrier_q - 12'h001;
        end else begin
          carrier_d = carrier_q + 12'h001;
        end
      end else begin
        if (carrier_q == 12'h000) begin
          dir_d     = bpct_pkg::BPCT_UP;
          half_end  = 1'b1;
          carrier_d = (i_carrier_period_max == 12'h000) ? 12'h000 : 12'h001;
        end else begin
          carrier_d = carrier_q - 12'h001;
        end
      end
    end
    // Fire on the (repetition+1)th half-cycle end
    if (half_end) begin
      if (rep_q >= i_update_repetition_count) begin
        rep_d = 8'h00;
        upd_d = 1'b1;  // Odd counts land on zero: mid on-time
      end else begin
        rep_d = rep_q + 8'h01;
      end
    end
    // Software writes go to the preload stage only
    if (i_duty_wr) begin
      pre_d = i_duty;
    end
    // Preload becomes active exactly at the update event
    if (upd_d) begin
      duty_d = {pre_d.hi[3:0], pre_d.lo};
    end
    // On while carrier is below compare, centred on zero
    pwm_d = (carrier_d < duty_d);
    // Writing zero clears; a same-cycle event still sets
    pend_d = pend_q;
    if (i_irq_status_wr && !i_irq_status_data[bpct_pkg::PEND_BIT]) begin
      pend_d = 1'b0;
    end
    if (upd_d) begin
      pend_d = 1'b1;
    end
    // PWM to one switch, user leg held on
    sw_d = (pwm_d ? onehot(pwm_leg(step_q)) : 6'h00) | onehot(i_comp_switch);
  end

  // Registers of the carrier group
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      presc_q   <= 16'h0000;
      carrier_q <= bpct_pkg::CARRIER_RST;
      dir_q     <= bpct_pkg::BPCT_UP;
      rep_q     <= 8'h00;
      pre_q     <= '{hi: bpct_pkg::BYTE_RST, lo: bpct_pkg::BYTE_RST};
      duty_q    <= bpct_pkg::CARRIER_RST;
      pwm_q     <= 1'b0;
      upd_q     <= 1'b0;
      pend_q    <= 1'b0;
      sw_q      <= 6'h00;
    end else begin
      presc_q   <= presc_d;
      carrier_q <= carrier_d;
      dir_q     <= dir_d;
      rep_q     <= rep_d;
      pre_q     <= pre_d;
      duty_q    <= duty_d;
      pwm_q     <= pwm_d;
      upd_q     <= upd_d;
      pend_q    <= pend_d;
      sw_q      <= sw_d;
    end
  end

  // Interval timer, captures, delay unit and commutation step
  always_comb begin
    logic        zc;
    logic        tick;
    logic [23:0] lim;
    logic [15:0] prod;
    // Only the source picked by i_zc_use_hall counts as the zero-cross event
    zc      = i_zc_use_hall ? i_zc_hall : i_zc_bemf;
    lim     = (24'(TB_DIV) << scale_q) - 24'h000001;
    tick    = (tb_q >= lim);
    prod    = tmr_q * i_commutation_delay_weight;
    tb_d    = tick ? 24'h000000 : tb_q + 24'h000001;
    tmr_d   = tmr_q;
    scale_d = scale_q;
    cur_d   = cur_q;
    prev_d  = prev_q;
    tgt_d   = tgt_q;
    dly_d   = dly_q;
    armed_d = armed_q;
    com_d   = 1'b0;
    step_d  = step_q;
    if (zc) begin
      prev_d  = cur_q;               // Old capture kept first
      cur_d   = tmr_q;               // Capture and restart
      tmr_d   = 8'h00;
      tb_d    = 24'h000000;
      tgt_d   = {1'b0, prod[15:bpct_pkg::WEIGHT_SH]};
      dly_d   = 9'h000;
      armed_d = 1'b1;
      // Short interval: finer timebase, target doubled to match
      if (tmr_q < bpct_pkg::TIMER_LOW && scale_q != bpct_pkg::SCALE_RST) begin
        scale_d = scale_q - 4'h1;
        tgt_d   = {prod[15:bpct_pkg::WEIGHT_SH], 1'b0};
      end
    end else if (tick) begin
      if (tmr_q == bpct_pkg::TIMER_FULL) begin
        // Overflow: coarser timebase, counts halved
        if (scale_q != bpct_pkg::SCALE_MAX) begin
          scale_d = scale_q + 4'h1;
          tmr_d   = bpct_pkg::TIMER_HALF;
          dly_d   = dly_q >> 1;
          tgt_d   = tgt_q >> 1;
        end
      end else begin
        tmr_d = tmr_q + 8'h01;
      end
      // Delay elapsed: commutate and advance the step
      if (armed_q) begin
        dly_d = dly_d + 9'h001;
        if (dly_d >= tgt_d) begin
          armed_d = 1'b0;
          com_d   = 1'b1;
          step_d  = (step_q == bpct_pkg::STEP_LAST) ? 3'h0 : step_q + 3'h1;
        end
      end
    end
  end

  // Registers of the interval group
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tb_q    <= 24'h000000;
      tmr_q   <= 8'h00;
      scale_q <= bpct_pkg::SCALE_RST;
      cur_q   <= bpct_pkg::BYTE_RST;
      prev_q  <= bpct_pkg::BYTE_RST;
      tgt_q   <= 9'h000;
      dly_q   <= 9'h000;
      armed_q <= 1'b0;
      com_q   <= 1'b0;
      step_q  <= 3'h0;
    end else begin
      tb_q    <= tb_d;
      tmr_q   <= tmr_d;
      scale_q <= scale_d;
      cur_q   <= cur_d;
      prev_q  <= prev_d;
      tgt_q   <= tgt_d;
      dly_q   <= dly_d;
      armed_q <= armed_d;
      com_q   <= com_d;
      step_q  <= step_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_switch                   = sw_q;
  assign o_pwm                      = pwm_q;
  assign o_carrier                  = carrier_q;
  assign o_duty_update_event        = upd_q;
  assign o_duty_update_pending_flag = pend_q;
  assign o_commutate                = com_q;
  assign o_step                     = step_q;
  assign o_interval                 = '{cur: cur_q, prev: prev_q,
                                        scale: scale_q};
endmodule

//--- testbench/bpct_checker.sv
// Port-level assertions for the brushless PWM and commutation timer
`timescale 1ns/100ps
module bpct_checker (
  input wire logic                     i_clk,                     // Clock
  input wire logic                     i_srst,                    // Reset
  input wire logic                     i_zc_bemf,                 // Bemf zc
  input wire logic                     i_zc_hall,                 // Hall zc
  input wire logic                     i_zc_use_hall,             // Source
  input wire logic [11:0]              i_carrier_period_max,      // Top
  input wire logic [7:0]               i_update_repetition_count, // Rep
  input wire logic                     i_duty_wr,                 // Strobe
  input wire bpct_pkg::bpct_duty_t     i_duty,                    // Duty
  input wire logic [2:0]               i_comp_switch,             // Comp
  input wire logic                     i_irq_status_wr,           // Strobe
  input wire logic [7:0]               i_irq_status_data,         // Data
  input wire logic [5:0]               o_switch,                  // Gates
  input wire logic                     o_pwm,                     // PWM
  input wire logic [11:0]              o_carrier,                 // Carrier
  input wire logic                     o_duty_update_event,       // Update
  input wire logic                     o_duty_update_pending_flag, // Flag
  input wire logic                     o_commutate,               // Commute
  input wire logic [2:0]               o_step,                    // Step
  input wire bpct_pkg::bpct_interval_t o_interval                 // Captures
);
  logic        live_q; // Low on the first edge out of reset
  logic        seen_q; // An update event has been seen
  logic [20:0] gap_q;  // Cycles since the last update event
  logic [11:0] pre_q;  // Shadow of the duty preload
  logic [11:0] cmp_q;  // Shadow of the active compare
  logic        zc;     // Selected zero-cross pulse
  assign zc = i_zc_use_hall ? i_zc_hall : i_zc_bemf;
  // Shadow state rebuilt from the ports
  always_ff @(posedge i_clk) begin
    live_q <= !i_srst;
    if (i_srst) begin
      seen_q <= 1'b0;
      gap_q  <= 21'h0;
      pre_q  <= 12'h0;
      cmp_q  <= 12'h0;
    end else begin
      seen_q <= seen_q | o_duty_update_event;
      gap_q  <= o_duty_update_event ? 21'h1 : gap_q + 21'h1;
      if (i_duty_wr) pre_q <= {i_duty.hi[3:0], i_duty.lo};
      if (o_duty_update_event) cmp_q <= pre_q;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_carrier_walk: assert property (
    live_q |-> o_carrier <= i_carrier_period_max &&
    (o_carrier == $past(o_carrier) + 12'h1 ||
     o_carrier + 12'h1 == $past(o_carrier)))
    else $error("carrier left its up-down walk");
  a_update_gap: assert property (
    o_duty_update_event && seen_q |-> gap_q ==
    (21'(i_update_repetition_count) + 21'h1) * 21'(i_carrier_period_max))
    else $error("update events spaced wrongly");
  a_update_mid: assert property (
    o_duty_update_event |-> o_carrier == 12'h1 && $past(o_carrier) == 12'h0)
    else $error("update event not at carrier bottom");
  a_pwm_compare: assert property (
    live_q && !o_duty_update_event && !$past(o_duty_update_event) |->
    o_pwm == (o_carrier < cmp_q))
    else $error("pwm disagrees with active compare");
  a_flag_set: assert property (
    o_duty_update_event && !i_irq_status_wr |=> o_duty_update_pending_flag)
    else $error("pending flag not set by update");
  a_flag_write: assert property (
    i_irq_status_wr && !o_duty_update_event |=> o_duty_update_event ||
    o_duty_update_pending_flag == ($past(o_duty_update_pending_flag) &&
                                   $past(i_irq_status_data[0])))
    else $error("status write handled wrongly");
  a_zc_shift: assert property (
    zc |=> o_interval.prev == $past(o_interval.cur))
    else $error("previous capture not shifted");
  a_zc_ignore: assert property (
    !zc && (i_zc_bemf || i_zc_hall) |=> $stable(o_interval.cur))
    else $error("unselected source captured");
  a_step_next: assert property (
    $changed(o_step) |-> (o_commutate || $past(o_commutate)) && o_step ==
    (($past(o_step) == 3'h5) ? 3'h0 : $past(o_step) + 3'h1))
    else $error("step moved without commutation");
  a_switch_map: assert property (
    live_q |-> o_switch == ((o_pwm ? 6'h1 << {$past(o_step[2:1]), 1'b0}
    : 6'h0) | (($past(i_comp_switch) < 3'h6) ? 6'h1 << $past(i_comp_switch)
    : 6'h0)))
    else $error("gate drives steered wrongly");
endmodule

bind bpct_timer bpct_checker bpct_checker_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_zc_bemf(i_zc_bemf),
  .i_zc_hall(i_zc_hall), .i_zc_use_hall(i_zc_use_hall),
  .i_carrier_period_max(i_carrier_period_max),
  .i_update_repetition_count(i_update_repetition_count),
  .i_duty_wr(i_duty_wr), .i_duty(i_duty), .i_comp_switch(i_comp_switch),
  .i_irq_status_wr(i_irq_status_wr), .i_irq_status_data(i_irq_status_data),
  .o_switch(o_switch), .o_pwm(o_pwm), .o_carrier(o_carrier),
  .o_duty_update_event(o_duty_update_event),
  .o_duty_update_pending_flag(o_duty_update_pending_flag),
  .o_commutate(o_commutate), .o_step(o_step), .o_interval(o_interval));

//--- testbench/bpct_motor_model.sv
// Motor and bridge stand-in that produces zero-cross pulses
`timescale 1ns/100ps
module bpct_motor_model (
  input  wire logic        i_clk,     // Clock
  input  wire logic        i_srst,    // Sync reset
  input  wire logic [15:0] i_gap,     // Crossing spacing minus one
  output logic             o_zc_bemf, // Back-EMF crossing pulse
  output logic             o_zc_hall  // Hall edge, half a gap later
);
  logic [15:0] cnt_q; // Cycles since the last back-EMF crossing
  // A slower motor is a longer gap; both sources stay one cycle wide
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= (cnt_q >= i_gap) ? 16'h0 : cnt_q + 16'h1;
    end
  end
  assign o_zc_bemf = !i_srst && cnt_q == i_gap;
  assign o_zc_hall = !i_srst && cnt_q == (i_gap >> 1);
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the brushless PWM and commutation timer
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  err_count++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  logic                     i_clk = 1'b0;            // 50 MHz clock
  logic                     i_srst = 1'b1;           // Sync reset
  logic                     use_hall, duty_wr, st_wr; // Control strobes
  logic [7:0]               weight, rep, st_data;    // Level settings
  logic [11:0]              maxv;                    // Carrier top
  logic [2:0]               comp;                    // Complementary switch
  logic [15:0]              gap;                     // Crossing spacing
  bpct_pkg::bpct_duty_t     duty;                    // Duty bytes
  logic                     zc_b, zc_h, pwm, ev, flag, comm; // Events
  logic [11:0]              car;                     // Carrier count
  logic [5:0]               sw;                      // Gate drives
  logic [2:0]               step;                    // Commutation step
  bpct_pkg::bpct_interval_t itv;                     // Captures
  int                       err_count, num_checks, seed, cyc, t_ev;
  int                       n, e, dv, hi;            // Scratch
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  bpct_timer #(.PRESC(1), .TB_DIV(4)) bpct_timer_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_zc_bemf(zc_b), .i_zc_hall(zc_h),
    .i_zc_use_hall(use_hall), .i_commutation_delay_weight(weight),
    .i_carrier_period_max(maxv), .i_update_repetition_count(rep),
    .i_duty_wr(duty_wr), .i_duty(duty), .i_comp_switch(comp),
    .i_irq_status_wr(st_wr), .i_irq_status_data(st_data), .o_switch(sw),
    .o_pwm(pwm), .o_carrier(car), .o_duty_update_event(ev),
    .o_duty_update_pending_flag(flag), .o_commutate(comm), .o_step(step),
    .o_interval(itv));
  bpct_motor_model bpct_motor_model_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_gap(gap), .o_zc_bemf(zc_b), .o_zc_hall(zc_h));
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Wait for an update event, optionally checking its spacing
  task automatic wait_ev(input bit chk);
    n = 0;
    do begin @(negedge i_clk); n++; end while (ev !== 1'b1 && n < 9000);
    `CHK("update wait", 1'b1, ev)
    if (chk) `CHK("update gap", (rep + 1) * maxv, cyc - t_ev)
    t_ev = cyc;
  endtask
  // Count PWM high cycles over one full carrier period
  task automatic pwm_cnt;
    hi = 0;
    repeat (2 * maxv) begin @(negedge i_clk); hi += int'(pwm === 1'b1); end
  endtask
  function automatic int exp_hi(int c, int m);
    return (c == 0) ? 0 : (c > m) ? 2 * m : 2 * c - 1;
  endfunction
  task automatic status_wr(input logic [7:0] d);
    @(posedge i_clk);
    st_wr <= 1'b1;
    st_data <= d;
    @(posedge i_clk);
    st_wr <= 1'b0;
    @(negedge i_clk);
  endtask
  // Wait for the selected crossing, then check the capture shift
  task automatic wait_zc;
    logic [7:0] old;
    n = 0;
    do begin @(negedge i_clk); n++; end
    while ((use_hall ? zc_h : zc_b) !== 1'b1 && n < 4000);
    `CHK("crossing wait", 1'b1, use_hall ? zc_h : zc_b)
    old = itv.cur;
    @(negedge i_clk);
    `CHK("prev capture", old, itv.prev)
  endtask
  // Two runs: back-EMF then Hall source, random timing settings
  initial begin
    seed = 67; use_hall = 0; duty_wr = 0; st_wr = 0; weight = 8'h0;
    rep = 8'h3; st_data = 8'h0; maxv = 12'h8; comp = 3'h0; gap = 16'h18f;
    duty = '0;
    for (int r = 0; r < 2; r++) begin
      @(posedge i_clk);
      i_srst <= 1'b1;
      use_hall <= r[0];
      gap <= 16'h18f;
      maxv <= 12'(8 + {$random(seed)} % 33);
      rep <= 8'(3 + 2 * ({$random(seed)} % 3));
      weight <= 8'({$random(seed)} % 192);
      comp <= r ? 3'h7 : 3'({$random(seed)} % 6);
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      wait_ev(0);
      wait_ev(1);  // Flag looked at first, at once
      `CHK("flag set", 1'b1, flag)
      status_wr(8'hff);  // Other bits only after the flag
      `CHK("flag kept", 1'b1, flag)
      status_wr(8'hfe);  // Clear is the last act of service
      `CHK("flag clear", 1'b0, flag)
      dv = (r == 0) ? 1 + {$random(seed)} % maxv : maxv + 1;
      @(posedge i_clk);
      duty_wr <= 1'b1;
      duty <= '{hi: {4'($random(seed)), 4'(dv >> 8)}, lo: 8'(dv)};
      @(posedge i_clk);
      duty_wr <= 1'b0;
      pwm_cnt;
      `CHK("pwm before update", 0, hi)
      wait_ev(1);
      @(negedge i_clk);
      pwm_cnt;
      `CHK("pwm duty", exp_hi(dv, maxv), hi)
      for (int k = 0; k < 9; k++) begin
        if (k == 2) gap <= 16'hbb7;
        if (k == 5) gap <= 16'h18f;
        wait_zc;
        if (k == 4) `CHK("scale up", 1'b1, itv.scale != 4'h0)
      end
      `CHK("scale down", 4'h0, itv.scale)
      `CHK("interval", 1'b1, itv.cur >= 8'h62 && itv.cur <= 8'h66)
      e = (int'(itv.cur) * int'(weight)) >> 8;
      e = 4 * ((e > 0) ? e : 1);
      n = 0;
      do begin @(negedge i_clk); n++; end while (comm !== 1'b1 && n < 600);
      `CHK("commutate delay", 1'b1, n >= e - 2 && n <= e + 3)
    end
    conclude;
  end
  // Hang guard
  initial begin
    #(20 * 80000);
    $display("Error watchdog expected finish seen timeout");
    err_count++;
    conclude;
  end
endmodule
